// ### logic/osse_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - hold set: stop switch, raise interrupt
// - hold clear: switch when source ready
// - secondary power bit selects high/low power
// - switch done when current equals requested
// - new source ready: switching and ready
// - ready flag may be very brief
// - per-oscillator ready bits at 7..2
// - multiplier ready: enabled, input ready, locked
// - force-on keeps oscillator running, reset 0
// - forced oscillator runs with own settings
// - mid-frequency needs high-frequency running
// - six-bit signed trim, reset center
// - current source uses requested encoding
module osse_top
   import osse_pkg::*;
#(
   parameter logic [2:0] RST_SRC = 3'h6, // source taken at reset
   parameter logic [3:0] RST_DIV = 4'h2
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [15:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [15:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // request side of the unit, same clock
   input wire logic [2:0] requested_source,
   input wire logic [3:0] requested_divider,
   input wire logic [5:0] periph_request,
   // analog oscillator flags, asynchronous
   input wire logic [5:0] osc_ready_raw,
   input wire logic pll_locked_raw,
   // oscillator controls
   output logic [5:0] osc_run,
   output logic pll_enable,
   output logic secondary_power_mode,
   output logic [5:0] trim_value,
   output logic [2:0] current_source,
   output logic [3:0] current_divider,
   output logic irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   osse_state_type st; // registered state
   osse_state_type next_st; // next state
   logic [5:0] rdy; // gated oscillator ready
   logic pll_rdy; // multiplier_ready
   logic pll_in_rdy; // multiplier input source ready
   logic sel_rdy; // requested source ready
   logic pending; // switch in progress
   logic nsr; // new_source_ready
   logic done; // switch_done
   logic do_switch; // switch taken this cycle
   logic held; // switch waiting on hold
   logic [1:0] ev; // event pulses
   logic [31:0] rd_mux; // read data
   logic rd_ok; // read address mapped
   // ----------------------------------------
   // oscillator run and readiness
   // ----------------------------------------
   always_comb begin
      osc_run = st.force_on | periph_request;
      // mid-frequency taps come off the high-frequency one
      osc_run[OSSE_HF] = osc_run[OSSE_HF] | osc_run[OSSE_MF];
      // not enabled reads as not ready, whatever the analog flag says
      rdy = st.sync2[6:1] & osc_run;
      pll_enable = (st.cur_src == OSSE_SRC_EXT_PLL) || (st.cur_src == OSSE_SRC_HF_PLL)
         || (requested_source == OSSE_SRC_EXT_PLL) || (requested_source == OSSE_SRC_HF_PLL);
      pll_in_rdy = (requested_source == OSSE_SRC_EXT_PLL) ? rdy[OSSE_EXT] : rdy[OSSE_HF];
      pll_rdy = pll_enable & pll_in_rdy & st.sync2[0];
      // readiness of the requested source, encoding as current_source
      case (requested_source)
         OSSE_SRC_EXT: sel_rdy = rdy[OSSE_EXT];
         OSSE_SRC_HF: sel_rdy = rdy[OSSE_HF];
         OSSE_SRC_LF: sel_rdy = rdy[OSSE_LF];
         OSSE_SRC_SEC: sel_rdy = rdy[OSSE_SEC];
         OSSE_SRC_EXT_PLL: sel_rdy = pll_rdy;
         OSSE_SRC_HF_PLL: sel_rdy = pll_rdy;
         default: sel_rdy = 1'b0; // reserved codes never switch
      endcase
   end
   // ----------------------------------------
   // clock switch handshake
   // ----------------------------------------
   always_comb begin
      done = (st.cur_src == requested_source) && (st.cur_div == requested_divider);
      pending = !done;
      nsr = pending & sel_rdy;
      // without hold the flag lasts one cycle only, polling may miss it
      do_switch = nsr & !st.hold;
      held = nsr & st.hold;
      ev = 2'h0;
      ev[OSSE_EV_HELD] = held & !st.held_seen;
      ev[OSSE_EV_DONE] = do_switch;
   end
   // ----------------------------------------
   // read decode
   // ----------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok = (s_araddr[1:0] == 2'h0);
      case (s_araddr[13:2])
         OSSE_IDX_SWITCH: begin
            rd_mux[OSSE_POS_HOLD] = st.hold;
            rd_mux[OSSE_POS_SECPWR] = st.sec_pwr;
            rd_mux[OSSE_POS_DONE] = done;
            rd_mux[OSSE_POS_NSR] = nsr;
         end
         OSSE_IDX_STATUS: begin
            rd_mux[7:OSSE_POS_OSC] = rdy;
            rd_mux[OSSE_POS_MULTIPLIER_READY] = pll_rdy;
         end
         OSSE_IDX_FORCE: rd_mux[7:OSSE_POS_OSC] = st.force_on;
         OSSE_IDX_TRIM: rd_mux[5:0] = st.trim;
         OSSE_IDX_CURRENT: rd_mux[6:0] = {st.cur_src, st.cur_div};
         OSSE_IDX_INT_STAT: rd_mux[1:0] = st.int_stat;
         OSSE_IDX_INT_CLR: rd_mux[1:0] = 2'h0; // write only
         OSSE_IDX_INT_EN: rd_mux[1:0] = st.int_en;
         default: rd_ok = 1'b0;
      endcase
      // only the low window of the map answers, the rest is an error
      if (s_araddr[15:14] != 2'h0) begin
         rd_ok = 1'b0;
      end
   end
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      // two-stage sync of analog flags
      next_st.sync1 = {osc_ready_raw, pll_locked_raw};
      next_st.sync2 = st.sync1;
      // write channels taken in either order
      if (s_awvalid && s_awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = s_awaddr[13:2];
         // out-of-range or misaligned address parks on an unmapped index
         if (s_awaddr[15:14] != 2'h0 || s_awaddr[1:0] != 2'h0) begin
            next_st.aw_idx = '0;
         end
      end
      if (s_wvalid && s_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_wdata[7:0];
         next_st.wstrb0 = s_wstrb[0];
      end
      if (s_bvalid && s_bready) begin
         next_st.bvalid = 1'b0;
      end
      // event flags, a new event beats a clear in the same cycle
      next_st.int_stat = st.int_stat | ev;
      next_st.held_seen = held;
      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = OSSE_RESP_OKAY;
         if (st.wstrb0) begin
            case (st.aw_idx)
               OSSE_IDX_SWITCH: begin
                  next_st.hold = st.wdata[OSSE_POS_HOLD];
                  next_st.sec_pwr = st.wdata[OSSE_POS_SECPWR];
               end
               OSSE_IDX_FORCE: next_st.force_on = st.wdata[7:OSSE_POS_OSC];
               OSSE_IDX_TRIM: next_st.trim = st.wdata[5:0];
               OSSE_IDX_INT_CLR: next_st.int_stat = (st.int_stat & ~st.wdata[1:0]) | ev;
               OSSE_IDX_INT_EN: next_st.int_en = st.wdata[1:0];
               OSSE_IDX_STATUS, OSSE_IDX_CURRENT, OSSE_IDX_INT_STAT: begin
                  next_st.bresp = OSSE_RESP_OKAY; // read-only, write dropped
               end
               default: next_st.bresp = OSSE_RESP_SLVERR;
            endcase
         end
      end
      // read: one outstanding, answer next cycle
      if (s_rvalid && s_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_mux;
         next_st.rresp = rd_ok ? OSSE_RESP_OKAY : OSSE_RESP_SLVERR;
      end
      // commit the switch
      if (do_switch) begin
         next_st.cur_src = requested_source;
         next_st.cur_div = requested_divider;
      end
   end
   // ----------------------------------------
   // state register, frozen while ce is low
   // ----------------------------------------
   // reset acts even while ce is low, so a frozen block can still restart
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.force_on <= OSSE_FORCE_RST;
         st.trim <= OSSE_TRIM_RST;
         st.cur_src <= RST_SRC;
         st.cur_div <= RST_DIV;
      end else if (ce) begin
         st <= next_st;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_awready = !st.aw_got && ce;
   assign s_wready = !st.w_got && ce;
   assign s_bvalid = st.bvalid;
   assign s_bresp = st.bresp;
   assign s_arready = !st.rvalid && ce;
   assign s_rvalid = st.rvalid;
   assign s_rdata = st.rdata;
   assign s_rresp = st.rresp;
   assign secondary_power_mode = st.sec_pwr;
   assign trim_value = st.trim;
   assign current_source = st.cur_src;
   assign current_divider = st.cur_div;
   assign irq = |(st.int_stat & st.int_en);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // attempts that run into a reset are dropped by the disable
   property p_hold;
      (held && ce) |=> $stable(st.cur_src) && $stable(st.cur_div);
   endproperty
   a_hold: assert property (p_hold) else $error("held switch completed");
   property p_held_irq;
      (held && !st.held_seen && ce && st.int_en[OSSE_EV_HELD]) |=> irq;
   endproperty
   a_held_irq: assert property (p_held_irq) else $error("no hold interrupt");
   property p_switch;
      (do_switch && ce) |=> (st.cur_src == $past(requested_source));
   endproperty
   a_switch: assert property (p_switch) else $error("switch not taken");
   property p_done;
      (ce && !nsr) |=> $stable(current_source) && $stable(current_divider);
   endproperty
   a_done: assert property (p_done) else $error("source moved without ready");
   property p_nsr;
      nsr |-> (!done && sel_rdy);
   endproperty
   a_nsr: assert property (p_nsr) else $error("ready flag outside switch");
   property p_status;
      (s_arvalid && s_arready && s_araddr[13:2] == OSSE_IDX_STATUS)
         |=> (st.rdata[1] == 1'b0 && st.rdata[31:8] == 24'h0);
   endproperty
   a_status: assert property (p_status) else $error("reserved status bits set");
   property p_pll;
      pll_rdy |-> (pll_enable && st.sync2[0]);
   endproperty
   a_pll: assert property (p_pll) else $error("multiplier ready wrong");
   property p_force;
      $rose(aresetn) |-> (st.force_on == 6'h00 && st.trim == 6'h00);
   endproperty
   a_force: assert property (p_force) else $error("bad reset value");
   property p_mf;
      osc_run[OSSE_MF] |-> osc_run[OSSE_HF];
   endproperty
   a_mf: assert property (p_mf) else $error("mid without high frequency");
   property p_release;
      ($fell(st.hold) && nsr && ce) ##1 (requested_source == $past(requested_source)
         && requested_divider == $past(requested_divider)) |-> done;
   endproperty
   a_release: assert property (p_release) else $error("release did not switch");
   property p_nsr_brief;
      (nsr && !st.hold && ce) ##1 ($stable(requested_source) && $stable(requested_divider))
         |-> !nsr;
   endproperty
   a_nsr_brief: assert property (p_nsr_brief) else $error("ready flag lingered");
   property p_trim;
      (ce && st.aw_got && st.w_got && !st.bvalid && st.wstrb0 && st.aw_idx == OSSE_IDX_TRIM)
         |=> ({2'h0, trim_value} == ($past(st.wdata) & 8'h3f));
   endproperty
   a_trim: assert property (p_trim) else $error("trim write lost");
endmodule : osse_top
`default_nettype wire

// ### logic/osse_pkg.sv
`default_nettype none
package osse_pkg;
   // ----------------------------------------
   // register indexes, byte address = 4 * index
   // ----------------------------------------
   localparam logic [11:0] OSSE_IDX_SWITCH = 12'h88f; // clock_switch_control3
   localparam logic [11:0] OSSE_IDX_STATUS = 12'h890; // oscillator_ready_status
   localparam logic [11:0] OSSE_IDX_FORCE = 12'h891; // oscillator_force_enable
   localparam logic [11:0] OSSE_IDX_TRIM = 12'h892; // internal_osc_trim
   localparam logic [11:0] OSSE_IDX_CURRENT = 12'h8a0; // current source and divider
   localparam logic [11:0] OSSE_IDX_INT_STAT = 12'h8a1; // sticky events, read only
   localparam logic [11:0] OSSE_IDX_INT_CLR = 12'h8a2; // write one to clear
   localparam logic [11:0] OSSE_IDX_INT_EN = 12'h8a3; // interrupt enables
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int OSSE_POS_HOLD = 7; // switch_hold
   localparam int OSSE_POS_SECPWR = 6; // secondary_power_mode
   localparam int OSSE_POS_DONE = 4; // switch_done
   localparam int OSSE_POS_NSR = 3; // new_source_ready
   localparam int OSSE_POS_MULTIPLIER_READY = 0; // multiplier_ready
   localparam int OSSE_POS_OSC = 2; // lowest oscillator bit (converter)
   // oscillator index inside the six-bit vectors
   localparam int OSSE_EXT = 5;
   localparam int OSSE_HF = 4;
   localparam int OSSE_MF = 3;
   localparam int OSSE_LF = 2;
   localparam int OSSE_SEC = 1;
   localparam int OSSE_ADC = 0;
   // interrupt event bits
   localparam int OSSE_EV_HELD = 0;
   localparam int OSSE_EV_DONE = 1;
   // ----------------------------------------
   // source codes and reset values
   // ----------------------------------------
   localparam logic [2:0] OSSE_SRC_EXT = 3'h7;
   localparam logic [2:0] OSSE_SRC_HF = 3'h6;
   localparam logic [2:0] OSSE_SRC_LF = 3'h5;
   localparam logic [2:0] OSSE_SRC_SEC = 3'h4;
   localparam logic [2:0] OSSE_SRC_EXT_PLL = 3'h2;
   localparam logic [2:0] OSSE_SRC_HF_PLL = 3'h1;
   localparam logic [5:0] OSSE_FORCE_RST = 6'h00;
   localparam logic [5:0] OSSE_TRIM_RST = 6'h00; // calibrated center
   localparam logic [1:0] OSSE_RESP_OKAY = 2'h0;
   localparam logic [1:0] OSSE_RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // state carrier
   // ----------------------------------------
   typedef struct packed {
      logic aw_got; // write address held
      logic [11:0] aw_idx;
      logic w_got; // write data held
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic hold; // switch_hold
      logic sec_pwr; // secondary_power_mode
      logic [5:0] force_on; // manual enables
      logic [5:0] trim; // trim_value
      logic [2:0] cur_src; // current_source
      logic [3:0] cur_div;
      logic [1:0] int_stat;
      logic [1:0] int_en;
      logic held_seen; // hold event already flagged
      logic [6:0] sync1; // first synchroniser stage
      logic [6:0] sync2; // second synchroniser stage
   } osse_state_type;
endpackage : osse_pkg
`default_nettype wire

// ### verification/osse_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// compare helper, counts every check and every miss
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module osse_tb_top;
   import osse_pkg::*;
   // --------------------------------
   // stimulus and observed ports
   // --------------------------------
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic [15:0] s_awaddr = '0, s_araddr = '0;
   logic [31:0] s_wdata = '0, s_rdata;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [2:0] requested_source = 3'h6, current_source; // matches reset source
   logic [3:0] requested_divider = 4'h2, current_divider;
   logic [5:0] periph_request = '0, osc_ready_raw = 6'h3f, osc_run, trim_value, exp;
   logic pll_locked_raw = 1'b0, pll_enable, secondary_power_mode, irq;
   logic [5:0] tv [3] = '{6'h1f, 6'h20, 6'h00}; // max, min, center trim
   logic [2:0] src [3] = '{3'h7, 3'h2, 3'h6}; // external, external x4, internal
   int mismatches = 0, tests_run = 0, k;
   osse_top DUT (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .requested_source, .requested_divider,
      .periph_request, .osc_ready_raw, .pll_locked_raw, .osc_run, .pll_enable,
      .secondary_power_mode, .trim_value, .current_source, .current_divider, .irq);
   // 100 MHz clock
   always #5 aclk = ~aclk;
   // --------------------------------
   // bus tasks, handshakes judged at the falling edge before each rising one
   // --------------------------------
   task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic a, w, b;
      logic [1:0] r;
      s_awaddr <= {2'b00, i, 2'b00};
      s_wdata <= {24'h0, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      b = 1'b0;
      // no cycle count assumed, only the watchdog ends a stuck wait
      while (!b) begin
         @(negedge aclk);
         a = s_awvalid & s_awready;
         w = s_wvalid & s_wready;
         b = s_bvalid;
         r = s_bresp;
         @(posedge aclk);
         if (a) s_awvalid <= 1'b0;
         if (w) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
      // extra edge so the next call never re-drives bready in this step
      @(posedge aclk);
      `CHK(r, er)
   endtask : wr
   task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
      logic a, v;
      logic [31:0] d;
      logic [1:0] r;
      s_araddr <= {2'b00, i, 2'b00};
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge aclk);
         a = s_arvalid & s_arready;
         v = s_rvalid;
         d = s_rdata;
         r = s_rresp;
         @(posedge aclk);
         if (a) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
      @(posedge aclk);
      if (er == 2'h0) `CHK(d, {24'h0, e})
      `CHK(r, er)
   endtask : rd
   // bounded wait for the switch to land on a source
   task automatic wait_src(input logic [2:0] s);
      int n;
      for (n = 0; n < 20; n++) begin
         @(negedge aclk);
         if (current_source === s) break;
      end
      `CHK(current_source, s)
      @(posedge aclk);
   endtask : wait_src
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end
   // --------------------------------
   // test sequence
   // --------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OSSE_IDX_FORCE, 8'h00);
      rd(OSSE_IDX_TRIM, 8'h00);
      rd(OSSE_IDX_SWITCH, 8'h10);
      rd(OSSE_IDX_CURRENT, 8'h62);
      rd(OSSE_IDX_STATUS, 8'h00);
      $display("test reset done");
      // one forced oscillator at a time, mid also pulls high
      for (k = 0; k < 6; k++) begin
         exp = 6'h01 << k;
         if (k == OSSE_MF) exp[OSSE_HF] = 1'b1;
         wr(OSSE_IDX_FORCE, {6'h01 << k, 2'b00});
         @(negedge aclk);
         `CHK(osc_run, exp)
         @(posedge aclk);
         rd(OSSE_IDX_STATUS, {exp, 2'b00});
      end
      wr(OSSE_IDX_FORCE, 8'h00);
      periph_request <= 6'h04;
      @(posedge aclk);
      rd(OSSE_IDX_STATUS, 8'h10);
      periph_request <= 6'h00;
      wr(OSSE_IDX_FORCE, 8'hfc);
      s_wstrb <= 4'he;
      wr(OSSE_IDX_FORCE, 8'h00);
      s_wstrb <= 4'hf;
      rd(OSSE_IDX_FORCE, 8'hfc);
      osc_ready_raw <= 6'h2f;
      repeat (3) @(posedge aclk);
      rd(OSSE_IDX_STATUS, 8'hbc);
      osc_ready_raw <= 6'h3f;
      wr(OSSE_IDX_STATUS, 8'h00);
      rd(OSSE_IDX_STATUS, 8'hfc);
      $display("test enables done");
      for (k = 0; k < 3; k++) begin
         wr(OSSE_IDX_TRIM, {2'b00, tv[k]});
         rd(OSSE_IDX_TRIM, {2'b00, tv[k]});
         `CHK(trim_value, tv[k])
      end
      wr(OSSE_IDX_SWITCH, 8'h40);
      rd(OSSE_IDX_SWITCH, 8'h50);
      `CHK(secondary_power_mode, 1'b1)
      wr(OSSE_IDX_SWITCH, 8'h00);
      `CHK(secondary_power_mode, 1'b0)
      $display("test trim done");
      // free switch to low-frequency, done event raised
      wr(OSSE_IDX_INT_EN, 8'h03);
      requested_source <= OSSE_SRC_LF;
      requested_divider <= 4'h0;
      wait_src(OSSE_SRC_LF);
      rd(OSSE_IDX_SWITCH, 8'h10);
      rd(OSSE_IDX_CURRENT, 8'h50);
      rd(OSSE_IDX_INT_STAT, 8'h02);
      `CHK(irq, 1'b1)
      wr(OSSE_IDX_INT_CLR, 8'h02);
      rd(OSSE_IDX_INT_CLR, 8'h00);
      `CHK(irq, 1'b0)
      // held switch to secondary, not ready first
      // flag dropped before the request, so no stale ready passes the sync
      osc_ready_raw <= 6'h3d;
      wr(OSSE_IDX_SWITCH, 8'h80);
      requested_source <= OSSE_SRC_SEC;
      repeat (4) @(posedge aclk);
      rd(OSSE_IDX_SWITCH, 8'h80);
      `CHK(irq, 1'b0)
      osc_ready_raw <= 6'h3f;
      repeat (4) @(posedge aclk);
      rd(OSSE_IDX_SWITCH, 8'h88);
      rd(OSSE_IDX_INT_STAT, 8'h01);
      `CHK(current_source, OSSE_SRC_LF)
      `CHK(irq, 1'b1)
      wr(OSSE_IDX_SWITCH, 8'h00);
      wait_src(OSSE_SRC_SEC);
      rd(OSSE_IDX_SWITCH, 8'h10);
      rd(OSSE_IDX_INT_STAT, 8'h03);
      // masked event stays pending without irq
      wr(OSSE_IDX_INT_CLR, 8'h03);
      wr(OSSE_IDX_INT_EN, 8'h00);
      requested_source <= OSSE_SRC_HF;
      requested_divider <= 4'h2;
      wait_src(OSSE_SRC_HF);
      rd(OSSE_IDX_INT_STAT, 8'h02);
      `CHK(irq, 1'b0)
      wr(OSSE_IDX_INT_EN, 8'h02);
      `CHK(irq, 1'b1)
      wr(OSSE_IDX_INT_CLR, 8'h02);
      `CHK(irq, 1'b0)
      // clock enable low freezes a ready switch until it returns
      ce <= 1'b0;
      requested_source <= OSSE_SRC_LF;
      repeat (4) @(posedge aclk);
      `CHK(current_source, OSSE_SRC_HF)
      ce <= 1'b1;
      wait_src(OSSE_SRC_LF);
      $display("test switch done");
      // multiplier ready and source codes
      pll_locked_raw <= 1'b1;
      requested_source <= OSSE_SRC_HF_PLL;
      wait_src(OSSE_SRC_HF_PLL);
      rd(OSSE_IDX_STATUS, 8'hfd);
      `CHK(pll_enable, 1'b1)
      for (k = 0; k < 3; k++) begin
         requested_source <= src[k];
         wait_src(src[k]);
         rd(OSSE_IDX_CURRENT, {1'b0, src[k], 4'h2});
      end
      pll_locked_raw <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(OSSE_IDX_STATUS, 8'hfc);
      // reset in mid-run brings enables and source back to reset values
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OSSE_IDX_FORCE, 8'h00);
      rd(OSSE_IDX_SWITCH, 8'h10);
      rd(OSSE_IDX_CURRENT, 8'h62);
      // unmapped place answers with an error
      rd(12'h000, 8'h00, OSSE_RESP_SLVERR);
      wr(12'h000, 8'h00, OSSE_RESP_SLVERR);
      $display("test multiplier done");
      stop_test();
   end
endmodule : osse_tb_top
`default_nettype wire
